// ---- verilog/clkgen_params.svh ----
// Offsets, field positions, reset values and timing counts of the clock generator.
// Function
// - Powerup level of the strap pin picks single-rate (high) or double-rate (low) oscillator.
// - Full speed: double clock copies oscillator; slow mode: it comes from the divider.
// - With a single-rate oscillator the double clock equals the system clock.
// - A single-rate system clock drives the non-CPU logic outside the DRAM and ISA paths and is fed back.
// - The CPU clock equals the system clock but power management may halt it.
// - Optionally request a CPU clock stop before changing clock frequency.
// - Suspend acknowledge is used only when its enable bit is set.
// - The ISA clock divides the double clock input by a selectable factor.
// - The ISA address latch enable is high only in the ISA clock low phase.
// - The double clock input steps the DRAM machine and feeds the ISA divider.
// - Oscillator edges are the time base of the power management timers.
// - The advanced clock input times the cache SRAM write strobes.
`ifndef CLKGEN_PARAMS_SVH
`define CLKGEN_PARAMS_SVH

`define CFG_OFFSET 12'h038
`define STATUS_OFFSET 12'h03C
`define CFG_RESET 8'h00

`define CFG_SLOW_BIT 0
`define CFG_STOP_EN_BIT 1
`define CFG_SUSP_EN_BIT 2
`define CFG_HALT_BIT 3
`define CFG_ISA_SEL_LSB 4
`define CFG_SLOW_SEL_LSB 6

`define CLK_PERIOD_NS 10
`define STOP_WAIT_NS 2000
`define STOP_WAIT_CYCLES ((`STOP_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PM_PRESCALE 16'h0100

`endif

// ---- verilog/clkgen_pkg.sv ----
// Types shared by the clock generator files.
package clkgen_pkg;
    typedef enum logic [1:0] {
        ST_RUN,
        ST_STOP,
        ST_SWITCH
    } change_state_t;
    typedef logic [7:0] half_count_t;
endpackage : clkgen_pkg

// ---- verilog/clock_divider.sv ----
// Enable-driven divider that toggles its output every half_count ticks.
`timescale 1ns/1ns
module clock_divider (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clear,
    input wire logic tick,
    input wire clkgen_pkg::half_count_t half_count,
    output logic clk_out
);
    import clkgen_pkg::*;

    half_count_t count_reg;
    half_count_t count_next;
    logic clk_next;

    always_comb begin
        count_next = count_reg;
        clk_next = clk_out;
        if (clear) begin
            count_next = 8'h00;
            clk_next = 1'b0;
        end else if (tick) begin
            if (count_reg >= half_count - 8'h01) begin
                count_next = 8'h00;
                clk_next = ~clk_out;
            end else begin
                count_next = count_reg + 8'h01;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_reg <= 8'h00;
            clk_out <= 1'b0;
        end else begin
            count_reg <= count_next;
            clk_out <= clk_next;
        end
    end
endmodule : clock_divider

// ---- verilog/system_clock_generator.sv ----
// Clock generation and distribution unit with an AHB-Lite configuration slave.
//
// The register offsets and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ns
`include "clkgen_params.svh"
module system_clock_generator (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic osc_clock_in,
    input wire logic nmi_strap_in,
    input wire logic double_clock_in,
    input wire logic cache_write_timing_n,
    input wire logic system_reset_in,
    input wire logic suspend_ack_n,
    input wire logic isa_ale_request,
    input wire logic cache_write_request,
    output logic double_clock_out,
    output logic sys_clock_out,
    output logic cpu_clock_out,
    output logic cpu_stop_request_n,
    output logic isa_clock_out,
    output logic isa_ale_out,
    output logic dram_step,
    output logic pm_timer_tick,
    output logic sram_write_n
);
    import clkgen_pkg::*;

    localparam logic [15:0] STOP_WAIT = 16'(`STOP_WAIT_CYCLES);

    // Factor select 0..3 gives division by 2, 4, 6 or 8.
    function automatic half_count_t half_of(input logic [1:0] sel);
        half_of = {6'h00, sel} + 8'h01;
    endfunction : half_of

    // Bus slave state.
    logic wr_pending_reg, wr_pending_next;
    logic [11:0] wr_addr_reg, wr_addr_next;
    logic [31:0] hrdata_next;
    logic [7:0] cfg_reg, cfg_next;

    // Clock state.
    logic strap_taken_reg, strap_taken_next;
    logic osc_is_1x_reg, osc_is_1x_next;
    logic osc_prev_reg, dbl_prev_reg, base_prev_reg;
    logic slow_reg, slow_next;
    logic cpu_run_reg, cpu_run_next;
    logic sys_next, cpu_next, stop_n_next, ale_next, sram_n_next;
    change_state_t state_reg, state_next;
    logic [15:0] wait_reg, wait_next;
    logic [15:0] pm_count_reg, pm_count_next;
    logic [15:0] pm_pre_reg, pm_pre_next;
    logic pm_tick_next;

    logic osc_rise, dbl_rise, base, base_rise;
    logic slow_div_clk, isa_div_clk;
    logic addr_phase;

    assign addr_phase = hsel && htrans[1] && hready;
    assign osc_rise = osc_clock_in && !osc_prev_reg;
    assign dbl_rise = double_clock_in && !dbl_prev_reg;
    assign base = slow_reg ? slow_div_clk : osc_clock_in;
    assign base_rise = base && !base_prev_reg;

    clock_divider slow_div (
        .hclk(hclk),
        .hresetn(hresetn),
        .clear(system_reset_in),
        .tick(osc_rise),
        .half_count(half_of(cfg_reg[`CFG_SLOW_SEL_LSB +: 2])),
        .clk_out(slow_div_clk)
    );

    // The ISA divider counts the fed-back double clock, which is the buffered oscillator at full speed and the slow divider output in slow mode.
    clock_divider isa_div (
        .hclk(hclk),
        .hresetn(hresetn),
        .clear(system_reset_in),
        .tick(dbl_rise),
        .half_count(half_of(cfg_reg[`CFG_ISA_SEL_LSB +: 2])),
        .clk_out(isa_div_clk)
    );

    always_comb begin
        wr_pending_next = addr_phase && hwrite;
        wr_addr_next = haddr[11:0];
        hrdata_next = 32'h00000000;
        if (addr_phase && !hwrite) begin
            if (haddr[11:0] == `CFG_OFFSET) begin
                hrdata_next = {24'h000000, cfg_reg};
            end else if (haddr[11:0] == `STATUS_OFFSET) begin
                hrdata_next = {pm_count_reg, 11'h000, strap_taken_reg, cpu_run_reg,
                               !cpu_stop_request_n, slow_reg, osc_is_1x_reg};
            end
        end
        cfg_next = cfg_reg;
        if (wr_pending_reg && wr_addr_reg == `CFG_OFFSET) begin
            cfg_next = hwdata[7:0];
        end
        if (system_reset_in) begin
            cfg_next[`CFG_SLOW_BIT] = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pending_reg <= 1'b0;
            wr_addr_reg <= 12'h000;
            hrdata <= 32'h00000000;
            cfg_reg <= `CFG_RESET;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pending_reg <= wr_pending_next;
            wr_addr_reg <= wr_addr_next;
            hrdata <= hrdata_next;
            cfg_reg <= cfg_next;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Frequency change sequencer and derived clocks.
    always_comb begin
        strap_taken_next = 1'b1;
        osc_is_1x_next = strap_taken_reg ? osc_is_1x_reg : nmi_strap_in;
        state_next = state_reg;
        slow_next = slow_reg;
        stop_n_next = cpu_stop_request_n;
        wait_next = wait_reg;
        case (state_reg)
            ST_RUN: begin
                if (cfg_reg[`CFG_SLOW_BIT] != slow_reg) begin
                    if (cfg_reg[`CFG_STOP_EN_BIT]) begin
                        state_next = ST_STOP;
                        stop_n_next = 1'b0;
                        wait_next = 16'h0000;
                    end else begin
                        slow_next = cfg_reg[`CFG_SLOW_BIT];
                    end
                end
            end
            ST_STOP: begin
                wait_next = wait_reg + 16'h0001;
                // Without the enable the acknowledge may float, so only the timeout counts.
                if ((cfg_reg[`CFG_SUSP_EN_BIT] && !suspend_ack_n) ||
                    wait_reg >= STOP_WAIT - 16'h0001) begin
                    state_next = ST_SWITCH;
                end
            end
            ST_SWITCH: begin
                slow_next = cfg_reg[`CFG_SLOW_BIT];
                stop_n_next = 1'b1;
                state_next = ST_RUN;
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
        if (system_reset_in) begin
            state_next = ST_RUN;
            slow_next = 1'b0;
            stop_n_next = 1'b1;
        end
        sys_next = osc_is_1x_reg ? base
            : (base_rise ? !sys_clock_out : sys_clock_out);
        // The gate only moves while the system clock is low, so the CPU never sees a runt pulse.
        cpu_run_next = sys_next ? cpu_run_reg : (!cfg_reg[`CFG_HALT_BIT] || system_reset_in);
        cpu_next = sys_next && cpu_run_next;
        ale_next = isa_ale_request && !isa_div_clk;
        sram_n_next = !(cache_write_request && !cache_write_timing_n);
        pm_count_next = pm_count_reg;
        pm_pre_next = pm_pre_reg;
        pm_tick_next = 1'b0;
        if (osc_rise) begin
            if (pm_pre_reg >= `PM_PRESCALE - 16'h0001) begin
                pm_pre_next = 16'h0000;
                pm_count_next = pm_count_reg + 16'h0001;
                pm_tick_next = 1'b1;
            end else begin
                pm_pre_next = pm_pre_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strap_taken_reg <= 1'b0;
            osc_is_1x_reg <= 1'b0;
            osc_prev_reg <= 1'b0;
            dbl_prev_reg <= 1'b0;
            base_prev_reg <= 1'b0;
            state_reg <= ST_RUN;
            slow_reg <= 1'b0;
            wait_reg <= 16'h0000;
            cpu_run_reg <= 1'b1;
            cpu_stop_request_n <= 1'b1;
            double_clock_out <= 1'b0;
            sys_clock_out <= 1'b0;
            cpu_clock_out <= 1'b0;
            isa_clock_out <= 1'b0;
            isa_ale_out <= 1'b0;
            dram_step <= 1'b0;
            pm_timer_tick <= 1'b0;
            sram_write_n <= 1'b1;
            pm_count_reg <= 16'h0000;
            pm_pre_reg <= 16'h0000;
        end else begin
            strap_taken_reg <= strap_taken_next;
            osc_is_1x_reg <= osc_is_1x_next;
            osc_prev_reg <= osc_clock_in;
            dbl_prev_reg <= double_clock_in;
            base_prev_reg <= base;
            state_reg <= state_next;
            slow_reg <= slow_next;
            wait_reg <= wait_next;
            cpu_run_reg <= cpu_run_next;
            cpu_stop_request_n <= stop_n_next;
            double_clock_out <= base;
            sys_clock_out <= sys_next;
            cpu_clock_out <= cpu_next;
            isa_clock_out <= isa_div_clk;
            isa_ale_out <= ale_next;
            dram_step <= dbl_rise;
            pm_timer_tick <= pm_tick_next;
            sram_write_n <= sram_n_next;
            pm_count_reg <= pm_count_next;
            pm_pre_reg <= pm_pre_next;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // The copy check waits for the strap, since the first edge after reset still shows reset values.
    a_strap_hold: assert property (strap_taken_reg |=> $stable(osc_is_1x_reg))
        else $error("strap value changed after capture");
    a_full_copy: assert property (strap_taken_reg && $past(!slow_reg) |->
        double_clock_out == $past(osc_clock_in))
        else $error("double clock not a copy of oscillator");
    a_slow_copy: assert property ($past(slow_reg) |->
        double_clock_out == $past(slow_div_clk))
        else $error("double clock not from divider in slow mode");
    a_one_x_match: assert property ($past(osc_is_1x_reg) |->
        double_clock_out == sys_clock_out)
        else $error("double clock differs from system clock at single rate");
    a_sys_halving: assert property (!osc_is_1x_reg && base_rise |=>
        sys_clock_out != $past(sys_clock_out))
        else $error("system clock did not toggle on double clock edge");
    a_sys_hold: assert property (!osc_is_1x_reg && !base_rise |=>
        $stable(sys_clock_out))
        else $error("system clock moved without double clock edge");
    a_cpu_gate: assert property (cpu_clock_out |-> sys_clock_out)
        else $error("cpu clock high while system clock low");
    a_cpu_follow: assert property (sys_clock_out && cpu_run_reg |-> cpu_clock_out)
        else $error("running cpu clock missed a system clock high");
    a_gate_low: assert property ($changed(cpu_run_reg) |-> !sys_clock_out)
        else $error("cpu gate moved while system clock high");

    // Frequency change sequencer and system reset.
    a_stop_entry: assert property (state_reg == ST_RUN && !system_reset_in &&
        cfg_reg[`CFG_SLOW_BIT] != slow_reg && cfg_reg[`CFG_STOP_EN_BIT]
        |=> !cpu_stop_request_n)
        else $error("stop request not raised before mode change");
    a_direct_switch: assert property (state_reg == ST_RUN && !system_reset_in &&
        cfg_reg[`CFG_SLOW_BIT] != slow_reg && !cfg_reg[`CFG_STOP_EN_BIT]
        |=> slow_reg != $past(slow_reg))
        else $error("mode change without stop request not applied");
    a_stop_bound: assert property ($fell(cpu_stop_request_n) |->
        ##[1:202] cpu_stop_request_n)
        else $error("stop request held too long");
    a_ack_leave: assert property (state_reg == ST_STOP &&
        cfg_reg[`CFG_SUSP_EN_BIT] && !suspend_ack_n && !system_reset_in |=> state_reg == ST_SWITCH)
        else $error("enabled suspend acknowledge not honoured");
    a_ack_ignored: assert property (state_reg == ST_STOP &&
        !cfg_reg[`CFG_SUSP_EN_BIT] && !system_reset_in && wait_reg < STOP_WAIT - 16'h0001
        |=> state_reg == ST_STOP)
        else $error("stop wait left early although acknowledge is disabled");
    a_reset_full: assert property ($past(system_reset_in) |->
        !slow_reg && cpu_stop_request_n)
        else $error("system reset did not hold full speed");
    a_isa_clear: assert property ($past(system_reset_in, 2) |-> !isa_clock_out)
        else $error("ISA clock not cleared by system reset");

    // Divided clocks, strobes, timers and the bus read path.
    a_ale_low: assert property (isa_ale_out |-> !isa_clock_out)
        else $error("address latch enable during ISA clock high");
    a_isa_source: assert property ($changed(isa_clock_out) |->
        $past(dbl_rise, 2) || $past(system_reset_in, 2))
        else $error("ISA clock moved without double clock edge");
    a_dram_pulse: assert property (dram_step == $past(dbl_rise))
        else $error("dram step does not follow double clock edge");
    a_pm_base: assert property (pm_timer_tick |-> $past(osc_rise))
        else $error("timer tick without oscillator edge");
    a_pm_count: assert property (pm_timer_tick |->
        pm_count_reg == $past(pm_count_reg) + 16'h0001)
        else $error("timer count did not advance with its tick");
    a_cache_strobe: assert property (!sram_write_n |->
        $past(!cache_write_timing_n && cache_write_request))
        else $error("cache strobe outside advanced clock low");
    a_read_idle: assert property (!$past(addr_phase && !hwrite) |-> hrdata == 32'h00000000)
        else $error("read data not cleared outside a read data phase");

    c_slow_entry: cover property ($rose(slow_reg));
    c_stop_seq: cover property ($fell(cpu_stop_request_n) ##[1:202] $rose(cpu_stop_request_n));
    c_cpu_halt: cover property ($fell(cpu_run_reg));
    c_ale_pulse: cover property ($rose(isa_ale_out));
    c_two_x_toggle: cover property (!osc_is_1x_reg && $rose(sys_clock_out));
endmodule : system_clock_generator

// ---- testbench/cpu_side_model.sv ----
// Far side model: board feedback of the clocks and a CPU that answers stop requests.
`timescale 1ns/1ns
module cpu_side_model (
    input wire logic hclk,
    input wire logic double_clock_out,
    input wire logic sys_clock_out,
    input wire logic cpu_stop_request_n,
    input wire logic [7:0] ack_delay,
    output logic double_clock_in,
    output logic cache_write_timing_n,
    output logic suspend_ack_n
);
    int wait_count = 0;
    logic ack_n = 1'b1;
    assign suspend_ack_n = ack_n;
    assign double_clock_in = double_clock_out;
    // The unbuffered system clock serves as the advanced strobe clock on the board.
    assign cache_write_timing_n = sys_clock_out;
    // A slow CPU makes the device wait; the answer is withdrawn once the request is released.
    always @(posedge hclk) begin
        if (cpu_stop_request_n) begin
            wait_count <= 0;
            ack_n <= 1'b1;
        end else if (wait_count >= ack_delay) begin
            ack_n <= 1'b0;
        end else begin
            wait_count <= wait_count + 1;
        end
    end
endmodule : cpu_side_model

// ---- testbench/system_clock_generator_test.sv ----
// Self-checking bench of the clock generator with a cycle model of its outputs.
`timescale 1ns/1ns
`include "clkgen_params.svh"
module system_clock_generator_test;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, nmi_strap_in = 1'b1;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, seed = 32'h2800;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, osc_clock_in = 1'b0, system_reset_in = 1'b0, cache_write_timing_n;
    logic isa_ale_request = 1'b0, cache_write_request = 1'b0, double_clock_in, suspend_ack_n;
    logic double_clock_out, sys_clock_out, cpu_clock_out, cpu_stop_request_n, isa_clock_out;
    logic isa_ale_out, dram_step, pm_timer_tick, sram_write_n;
    logic [7:0] ack_delay = 8'h01;
    logic p_osc = 0, p_ale = 0, p_cwr = 0, p_cwt = 1, p_din = 0, p_isa = 0;
    logic chk_fast = 0, chk_run = 0;
    int fail_count = 0, samples_checked = 0, n_osc, n_din, n_isa, n_step, n_tick, n_cpu;

    system_clock_generator system_clock_generator_inst (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .osc_clock_in(osc_clock_in), .nmi_strap_in(nmi_strap_in),
        .double_clock_in(double_clock_in), .cache_write_timing_n(cache_write_timing_n),
        .system_reset_in(system_reset_in), .suspend_ack_n(suspend_ack_n),
        .isa_ale_request(isa_ale_request), .cache_write_request(cache_write_request),
        .double_clock_out(double_clock_out), .sys_clock_out(sys_clock_out),
        .cpu_clock_out(cpu_clock_out), .cpu_stop_request_n(cpu_stop_request_n),
        .isa_clock_out(isa_clock_out), .isa_ale_out(isa_ale_out), .dram_step(dram_step),
        .pm_timer_tick(pm_timer_tick), .sram_write_n(sram_write_n));
    cpu_side_model cpu_side_model_inst (.hclk(hclk), .double_clock_out(double_clock_out),
        .sys_clock_out(sys_clock_out), .cpu_stop_request_n(cpu_stop_request_n),
        .ack_delay(ack_delay), .double_clock_in(double_clock_in),
        .cache_write_timing_n(cache_write_timing_n), .suspend_ack_n(suspend_ack_n));

    always #5 hclk = ~hclk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic check_bit(input string what, input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s expected %b seen %b", what, e, g);
        end
    endtask : check_bit

    task automatic check_word(input string what, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", what, e, g);
        end
    endtask : check_word

    task automatic check_near(input string what, input int e, input int g, input int tol);
        samples_checked++;
        if (g > e + tol || g < e - tol) begin
            fail_count++;
            $display("unexpected %s expected %0d seen %0d", what, e, g);
        end
    endtask : check_near

    // Address phase is held until ready is seen, then data phase until ready again.
    task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0, a};
        hwrite <= wr;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        rd = hrdata;
        if (n >= 100) begin
            fail_count++;
            report_and_stop();
        end
    endtask : ahb

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
                          input string what);
        ahb(1'b0, a, 32'h0);
        check_bit("hresp", 1'b0, hresp);
        check_word(what, e, rd & m);
    endtask : rd_chk

    task automatic do_reset(input logic strap);
        chk_run <= 1'b0;
        chk_fast <= 1'b0;
        hresetn <= 1'b0;
        nmi_strap_in <= strap;
        repeat (12) @(posedge hclk);
        check_bit("hreadyout", 1'b1, hreadyout);
        check_bit("stop_in_reset", 1'b1, cpu_stop_request_n);
        hresetn <= 1'b1;
        @(posedge hclk);
    endtask : do_reset

    task automatic stop_len(output int len);
        int n;
        n = 0;
        while (cpu_stop_request_n !== 1'b0 && n < 10) begin
            @(posedge hclk);
            n++;
        end
        len = 0;
        while (cpu_stop_request_n === 1'b0 && len < 400) begin
            @(posedge hclk);
            len++;
        end
        if (n >= 10 || len >= 400) begin
            fail_count++;
            report_and_stop();
        end
    endtask : stop_len

    always @(posedge hclk) begin
        seed <= xs(seed);
        osc_clock_in <= seed[0];
        isa_ale_request <= seed[9];
        cache_write_request <= seed[20];
    end

    // Reference model: outputs are predicted from inputs seen one edge earlier or from other outputs of the same edge.
    always @(posedge hclk) begin
        {p_osc, p_ale, p_cwr, p_cwt, p_din, p_isa} <= {osc_clock_in, isa_ale_request,
            cache_write_request, cache_write_timing_n, double_clock_in, isa_clock_out};
        if (chk_run) begin
            check_bit("isa_ale_out", p_ale & ~isa_clock_out, isa_ale_out);
            check_bit("sram_write_n", ~(p_cwr & ~p_cwt), sram_write_n);
            n_osc += osc_clock_in & ~p_osc;
            n_din += double_clock_in & ~p_din;
            n_isa += isa_clock_out & ~p_isa;
            n_step += dram_step;
            n_tick += pm_timer_tick;
            n_cpu += cpu_clock_out;
        end
        if (chk_fast) begin
            check_bit("double_clock_out", p_osc, double_clock_out);
            check_bit("sys_clock_out", double_clock_out, sys_clock_out);
            check_bit("cpu_clock_out", sys_clock_out, cpu_clock_out);
        end
    end

    initial begin
        repeat (100000) @(posedge hclk);
        fail_count++;
        report_and_stop();
    end

    initial begin
        int pm_base, len;
        do_reset(1'b1);
        rd_chk(`CFG_OFFSET, 32'hFFFFFFFF, 32'h0, "cfg_reset");
        rd_chk(`STATUS_OFFSET, 32'h1F, 32'h19, "status_reset");
        ahb(1'b1, 12'h040, 32'hFFFFFFFF);
        rd_chk(12'h040, 32'hFFFFFFFF, 32'h0, "unmapped");
        rd_chk(`CFG_OFFSET, 32'hFFFFFFFF, 32'h0, "cfg_after_unmapped");
        chk_run <= 1'b1;
        chk_fast <= 1'b1;
        ahb(1'b0, `STATUS_OFFSET, 32'h0);
        pm_base = rd[31:16];
        n_osc = 0;
        n_tick = 0;
        for (int sel = 0; sel < 4; sel++) begin
            ahb(1'b1, `CFG_OFFSET, 32'(sel << 4));
            repeat (20) @(posedge hclk);
            n_din = 0;
            n_isa = 0;
            n_step = 0;
            repeat (600) @(posedge hclk);
            check_near("isa_rises", n_din / (2 * (sel + 1)), n_isa, 1);
            check_near("dram_steps", n_din, n_step, 1);
        end
        ahb(1'b0, `STATUS_OFFSET, 32'h0);
        check_near("pm_ticks", n_osc / 256, n_tick, 1);
        check_near("pm_count", n_osc / 256, int'(rd[31:16]) - pm_base, 1);
        chk_fast <= 1'b0;
        ahb(1'b1, `CFG_OFFSET, 32'h8);
        repeat (10) @(posedge hclk);
        n_cpu = 0;
        repeat (100) @(posedge hclk);
        check_near("cpu_high_halted", 0, n_cpu, 0);
        rd_chk(`STATUS_OFFSET, 32'h8, 32'h0, "gate_closed");
        for (int i = 0; i < 2; i++) begin
            ack_delay <= i ? 8'h28 : 8'h01;
            ahb(1'b1, `CFG_OFFSET, 32'h7);
            stop_len(len);
            check_near("stop_to_slow", i ? 43 : 4, len, 2);
            rd_chk(`STATUS_OFFSET, 32'h6, 32'h2, "slow_active");
            ahb(1'b1, `CFG_OFFSET, 32'h6);
            stop_len(len);
            check_near("stop_to_fast", i ? 43 : 4, len, 2);
        end
        ack_delay <= 8'h01;
        ahb(1'b1, `CFG_OFFSET, 32'h3);
        stop_len(len);
        check_near("stop_ack_ignored", 201, len, 2);
        n_osc = 0;
        n_din = 0;
        repeat (400) @(posedge hclk);
        check_near("slow_double_rises", n_osc / 2, n_din, 1);
        ack_delay <= 8'h28;
        ahb(1'b1, `CFG_OFFSET, 32'h6);
        repeat (5) @(posedge hclk);
        system_reset_in <= 1'b1;
        repeat (2) @(posedge hclk);
        system_reset_in <= 1'b0;
        @(posedge hclk);
        check_bit("stop_after_system_reset_in", 1'b1, cpu_stop_request_n);
        rd_chk(`STATUS_OFFSET, 32'hE, 32'h8, "full_speed_after_system_reset_in");
        ahb(1'b1, `CFG_OFFSET, 32'h1);
        repeat (2) @(posedge hclk);
        rd_chk(`STATUS_OFFSET, 32'h6, 32'h2, "slow_direct");
        do_reset(1'b0);
        rd_chk(`STATUS_OFFSET, 32'h1F, 32'h18, "status_strap_2x");
        report_and_stop();
    end
endmodule : system_clock_generator_test
